/* File: csd_pkg.sv */
// Function
// - sync marker high throughout every opcode fetch cycle, low otherwise
// - ready low during the fetch cycle freezes the core until ready returns
// - no bus writes while reset is held low
// - reset sequence starts right at the reset release
// - after six init cycles set interrupt mask, load pc from fffc/fffd
// - cycle counter zeroed at each fetch, advanced every cycle otherwise
// - 16-bit pc drives the address bus and increments per program byte
// - fetched opcode latched into instruction register and decoded
// - one stateless alu does arithmetic, logic and register steps, not pc
// - 8-bit accumulator is main operand and result of alu operations
// - two 8-bit index registers added to base in indexed modes
// - 8-bit stack pointer addresses page one, steps on push and interrupt
// - 8-bit status register holds seven flags set by program and core
// - instruction set of loads, stores, alu, shifts, transfers, flags, jumps
// - accumulator mode is one byte long with no memory operand access
// - immediate mode uses the second byte as the operand
// - absolute mode address is second byte low, third byte high
// - page-zero mode uses second byte with high address byte forced zero
// - indexed page-zero adds index to second byte dropping the carry
// - ready low during a write is ignored until the next read cycle
// - interrupt entry loads pc low from fffe and high from ffff
package csd_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int CYC_W = 3;
  localparam logic [CYC_W-1:0] INIT_CYCLES = 3'h6;
  localparam logic [15:0] VEC_RESET = 16'hfffc;
  localparam logic [15:0] VEC_IRQ = 16'hfffe;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [7:0] ZERO_PAGE = 8'h00;
  localparam logic [7:0] SP_RESET = 8'hff;
  localparam logic [7:0] P_RESET = 8'h20;
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_I = 2;
  localparam int FL_D = 3;
  localparam int FL_B = 4;
  localparam int FL_V = 6;
  localparam int FL_N = 7;
  localparam logic [7:0] OP_JMP_ABS = 8'h4c;
  localparam logic [7:0] OP_PHA = 8'h48;
  localparam logic [7:0] OP_INX = 8'he8;
  localparam logic [7:0] OP_INY = 8'hc8;
  localparam logic [7:0] OP_DEX = 8'hca;
  localparam logic [7:0] OP_DEY = 8'h88;
  localparam logic [7:0] OP_TAX = 8'haa;
  localparam logic [7:0] OP_TAY = 8'ha8;
  localparam logic [7:0] OP_TXA = 8'h8a;
  localparam logic [7:0] OP_TYA = 8'h98;
  localparam logic [7:0] OP_TSX = 8'hba;
  localparam logic [7:0] OP_TXS = 8'h9a;
  localparam logic [7:0] OP_ASL_A = 8'h0a;
  localparam logic [7:0] OP_ROL_A = 8'h2a;
  localparam logic [7:0] OP_LSR_A = 8'h4a;
  localparam logic [7:0] OP_ROR_A = 8'h6a;
  localparam logic [7:0] OP_CLC = 8'h18;
  localparam logic [7:0] OP_SEC = 8'h38;
  localparam logic [7:0] OP_CLI = 8'h58;
  localparam logic [7:0] OP_SEI = 8'h78;
  localparam logic [7:0] OP_CLV = 8'hb8;
  localparam logic [7:0] OP_CLD = 8'hd8;
  localparam logic [7:0] OP_SED = 8'hf8;
  typedef enum logic [3:0] {
    S_INIT, S_VL, S_VH, S_FETCH, S_OP1, S_OP2, S_IDX,
    S_MEM, S_PUSH, S_IRQ1, S_IRQ2, S_IRQ3
  } csd_state_type;
  typedef enum logic [2:0] {
    implied_mode, immediate_operand_mode, page_zero_mode,
    page_zero_indexed_mode, absolute_mode
  } csd_mode_type;
  typedef enum logic [3:0] {
    ALU_PASS, ALU_OR, ALU_AND, ALU_EOR, ALU_ADC, ALU_SBC, ALU_CMP,
    ALU_INC, ALU_DEC, ALU_ASL, ALU_ROL, ALU_LSR, ALU_ROR
  } csd_alu_type;
endpackage

/* File: csd_core.sv */
`timescale 1ns/1ps
module csd_core (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // control inputs
  input wire logic ready,
  input wire logic irq_n,
  // memory bus
  output logic [csd_pkg::ADDR_W-1:0] addr_ff,
  input wire logic [csd_pkg::DATA_W-1:0] data_in,
  output logic [csd_pkg::DATA_W-1:0] data_out_ff,
  output logic data_oe_ff,
  output logic rw_ff,
  output logic sync_ff
);
  import csd_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  csd_state_type st_ff, nxt_st_ff;
  logic [CYC_W-1:0] cyc_ff, nxt_cyc_ff;
  logic [15:0] pc_ff, nxt_pc_ff;
  logic [7:0] ir_ff, nxt_ir_ff;
  logic [7:0] a_ff, nxt_a_ff;
  logic [7:0] x_ff, nxt_x_ff;
  logic [7:0] y_ff, nxt_y_ff;
  logic [7:0] sp_ff, nxt_sp_ff;
  logic [7:0] p_ff, nxt_p_ff;
  logic [7:0] lo_ff, nxt_lo_ff;
  logic vec_ff, nxt_vec_ff;
  logic [15:0] nxt_addr_ff;
  logic [7:0] nxt_data_out_ff;
  logic nxt_data_oe_ff;
  logic nxt_rw_ff;
  logic nxt_sync_ff;
  logic adv;
  logic done;
  logic exec_now;

  // read cycles stall on ready low; writes ignore ready and stall only on clk_en low
  assign adv = clk_en && (ready || !rw_ff);

  // ----------------------------------------
  // decode
  // ----------------------------------------
  csd_mode_type mode;
  logic [1:0] grp;
  logic [2:0] md;
  logic [2:0] opf;
  logic is_store;
  logic [7:0] store_val;
  logic [7:0] idx_val;

  assign grp = ir_ff[1:0];
  assign md = ir_ff[4:2];
  assign opf = ir_ff[7:5];
  assign is_store = (opf == 3'h4) && (grp != 2'h3);
  assign store_val = (grp == 2'h1) ? a_ff : ((grp == 2'h2) ? x_ff : y_ff);
  assign idx_val = (grp == 2'h2) ? y_ff : x_ff;

  // unlisted opcodes fall through as no-ops, two cycles long when decoded as implied
  always_comb begin
    mode = implied_mode;
    if (ir_ff == OP_JMP_ABS) begin
      mode = absolute_mode;
    end else if (grp == 2'h3 || ir_ff[3:0] == 4'h8 || ir_ff[3:0] == 4'ha) begin
      mode = implied_mode;
    end else if ((grp == 2'h1 && md == 3'h2) || (grp != 2'h1 && md == 3'h0 && ir_ff[7])) begin
      mode = immediate_operand_mode;
    end else if (md == 3'h1) begin
      mode = page_zero_mode;
    end else if (md == 3'h5) begin
      mode = page_zero_indexed_mode;
    end else if (md == 3'h3) begin
      mode = absolute_mode;
    end
  end

  // ----------------------------------------
  // operation select
  // ----------------------------------------
  csd_alu_type alu_op;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic [7:0] alu_r;
  logic alu_c;
  logic alu_v;
  logic [8:0] sum;
  logic wr_a, wr_x, wr_y, wr_sp;
  logic upd_nz, upd_c, upd_v;

  always_comb begin
    alu_op = ALU_PASS;
    alu_a = a_ff;
    alu_b = data_in;
    wr_a = 1'b0;
    wr_x = 1'b0;
    wr_y = 1'b0;
    wr_sp = 1'b0;
    upd_nz = 1'b0;
    upd_c = 1'b0;
    upd_v = 1'b0;
    if (mode == implied_mode) begin
      case (ir_ff)
        OP_INX, OP_DEX: begin
          // bit 6 is set in both codes, bit 5 tells them apart
          alu_op = ir_ff[5] ? ALU_INC : ALU_DEC;
          alu_a = x_ff;
          wr_x = 1'b1;
          upd_nz = 1'b1;
        end
        OP_INY, OP_DEY: begin
          alu_op = ir_ff[6] ? ALU_INC : ALU_DEC;
          alu_a = y_ff;
          wr_y = 1'b1;
          upd_nz = 1'b1;
        end
        OP_TAX, OP_TAY: begin
          alu_b = a_ff;
          wr_x = ir_ff[1];
          wr_y = !ir_ff[1];
          upd_nz = 1'b1;
        end
        OP_TXA, OP_TYA: begin
          alu_b = ir_ff[1] ? x_ff : y_ff;
          wr_a = 1'b1;
          upd_nz = 1'b1;
        end
        OP_TSX: begin
          alu_b = sp_ff;
          wr_x = 1'b1;
          upd_nz = 1'b1;
        end
        OP_TXS: begin
          alu_b = x_ff;
          wr_sp = 1'b1;
        end
        OP_ASL_A, OP_ROL_A, OP_LSR_A, OP_ROR_A: begin
          alu_op = csd_alu_type'(ALU_ASL + ir_ff[6:5]);
          wr_a = 1'b1;
          upd_nz = 1'b1;
          upd_c = 1'b1;
        end
        default: begin
        end
      endcase
    end else if (grp == 2'h1) begin
      upd_nz = !is_store;
      wr_a = !is_store && (opf != 3'h6);
      case (opf)
        3'h0: alu_op = ALU_OR;
        3'h1: alu_op = ALU_AND;
        3'h2: alu_op = ALU_EOR;
        3'h3: alu_op = ALU_ADC;
        3'h6: alu_op = ALU_CMP;
        3'h7: alu_op = ALU_SBC;
        default: alu_op = ALU_PASS;
      endcase
      upd_c = (opf == 3'h3) || (opf >= 3'h6);
      upd_v = (opf == 3'h3) || (opf == 3'h7);
    end else if (opf == 3'h5) begin
      wr_x = (grp == 2'h2);
      wr_y = (grp == 2'h0);
      upd_nz = 1'b1;
    end else if (opf >= 3'h6 && grp == 2'h0) begin
      alu_op = ALU_CMP;
      alu_a = opf[0] ? x_ff : y_ff;
      upd_nz = 1'b1;
      upd_c = 1'b1;
    end
  end

  // ----------------------------------------
  // alu, no storage; decimal mode not modelled
  // ----------------------------------------
  always_comb begin
    sum = 9'h000;
    alu_r = alu_b;
    alu_c = p_ff[FL_C];
    alu_v = p_ff[FL_V];
    case (alu_op)
      ALU_OR: alu_r = alu_a | alu_b;
      ALU_AND: alu_r = alu_a & alu_b;
      ALU_EOR: alu_r = alu_a ^ alu_b;
      ALU_ADC, ALU_SBC, ALU_CMP: begin
        sum = {1'b0, alu_a} + {1'b0, (alu_op == ALU_ADC) ? alu_b : ~alu_b}
            + {8'h00, (alu_op == ALU_CMP) ? 1'b1 : p_ff[FL_C]};
        alu_r = sum[7:0];
        alu_c = sum[8];
        alu_v = (alu_a[7] == ((alu_op == ALU_ADC) ? alu_b[7] : !alu_b[7]))
            && (alu_r[7] != alu_a[7]);
      end
      ALU_INC: alu_r = alu_a + 8'h01;
      ALU_DEC: alu_r = alu_a - 8'h01;
      ALU_ASL: {alu_c, alu_r} = {alu_a, 1'b0};
      ALU_ROL: {alu_c, alu_r} = {alu_a, p_ff[FL_C]};
      ALU_LSR: {alu_r, alu_c} = {1'b0, alu_a};
      ALU_ROR: {alu_r, alu_c} = {p_ff[FL_C], alu_a};
      default: alu_r = alu_b;
    endcase
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    nxt_st_ff = st_ff;
    nxt_cyc_ff = cyc_ff + 3'h1;
    nxt_pc_ff = pc_ff;
    nxt_ir_ff = ir_ff;
    nxt_a_ff = a_ff;
    nxt_x_ff = x_ff;
    nxt_y_ff = y_ff;
    nxt_sp_ff = sp_ff;
    nxt_p_ff = p_ff;
    nxt_lo_ff = lo_ff;
    nxt_vec_ff = vec_ff;
    nxt_addr_ff = addr_ff;
    nxt_data_out_ff = data_out_ff;
    nxt_data_oe_ff = 1'b0;
    nxt_rw_ff = 1'b1;
    nxt_sync_ff = 1'b0;
    done = 1'b0;
    exec_now = 1'b0;
    case (st_ff)
      S_INIT: begin
        if (cyc_ff == INIT_CYCLES - 3'h1) begin
          nxt_p_ff[FL_I] = 1'b1;
          nxt_vec_ff = 1'b0;
          nxt_addr_ff = VEC_RESET;
          nxt_st_ff = S_VL;
        end
      end
      S_VL: begin
        nxt_pc_ff[7:0] = data_in;
        nxt_addr_ff = (vec_ff ? VEC_IRQ : VEC_RESET) + 16'h0001;
        nxt_st_ff = S_VH;
      end
      S_VH: begin
        nxt_pc_ff[15:8] = data_in;
        done = 1'b1;
      end
      S_FETCH: begin
        nxt_ir_ff = data_in;
        nxt_pc_ff = pc_ff + 16'h0001;
        nxt_addr_ff = pc_ff + 16'h0001;
        nxt_st_ff = S_OP1;
      end
      S_OP1: begin
        nxt_lo_ff = data_in;
        case (mode)
          implied_mode: begin
            if (ir_ff == OP_PHA) begin
              nxt_addr_ff = {STACK_PAGE, sp_ff};
              nxt_data_out_ff = a_ff;
              nxt_data_oe_ff = 1'b1;
              nxt_rw_ff = 1'b0;
              nxt_sp_ff = sp_ff - 8'h01;
              nxt_st_ff = S_PUSH;
            end else begin
              exec_now = 1'b1;
              done = 1'b1;
            end
          end
          immediate_operand_mode: begin
            nxt_pc_ff = pc_ff + 16'h0001;
            exec_now = 1'b1;
            done = 1'b1;
          end
          page_zero_mode: begin
            nxt_pc_ff = pc_ff + 16'h0001;
            nxt_addr_ff = {ZERO_PAGE, data_in};
            nxt_st_ff = S_MEM;
          end
          page_zero_indexed_mode: begin
            nxt_pc_ff = pc_ff + 16'h0001;
            nxt_addr_ff = {ZERO_PAGE, data_in};
            nxt_st_ff = S_IDX;
          end
          default: begin
            nxt_pc_ff = pc_ff + 16'h0001;
            nxt_addr_ff = pc_ff + 16'h0001;
            nxt_st_ff = S_OP2;
          end
        endcase
      end
      S_IDX: begin
        // 8-bit add wraps inside page zero
        nxt_addr_ff = {ZERO_PAGE, lo_ff + idx_val};
        nxt_st_ff = S_MEM;
      end
      S_OP2: begin
        nxt_pc_ff = pc_ff + 16'h0001;
        if (ir_ff == OP_JMP_ABS) begin
          nxt_pc_ff = {data_in, lo_ff};
          done = 1'b1;
        end else begin
          nxt_addr_ff = {data_in, lo_ff};
          nxt_st_ff = S_MEM;
        end
      end
      S_MEM: begin
        exec_now = rw_ff;
        done = 1'b1;
      end
      S_PUSH: done = 1'b1;
      S_IRQ1: begin
        nxt_addr_ff = {STACK_PAGE, sp_ff};
        nxt_data_out_ff = pc_ff[7:0];
        nxt_data_oe_ff = 1'b1;
        nxt_rw_ff = 1'b0;
        nxt_sp_ff = sp_ff - 8'h01;
        nxt_st_ff = S_IRQ2;
      end
      S_IRQ2: begin
        nxt_addr_ff = {STACK_PAGE, sp_ff};
        nxt_data_out_ff = p_ff;
        nxt_data_out_ff[FL_B] = 1'b0;
        nxt_data_oe_ff = 1'b1;
        nxt_rw_ff = 1'b0;
        nxt_sp_ff = sp_ff - 8'h01;
        nxt_st_ff = S_IRQ3;
      end
      S_IRQ3: begin
        nxt_p_ff[FL_I] = 1'b1;
        nxt_vec_ff = 1'b1;
        nxt_addr_ff = VEC_IRQ;
        nxt_st_ff = S_VL;
      end
      default: nxt_st_ff = S_INIT;
    endcase
    if (st_ff == S_OP1 || st_ff == S_OP2 || st_ff == S_IDX) begin
      if (nxt_st_ff == S_MEM) begin
        nxt_rw_ff = !is_store;
        nxt_data_oe_ff = is_store;
        nxt_data_out_ff = store_val;
      end
    end
    if (exec_now) begin
      if (wr_a) nxt_a_ff = alu_r;
      if (wr_x) nxt_x_ff = alu_r;
      if (wr_y) nxt_y_ff = alu_r;
      if (wr_sp) nxt_sp_ff = alu_r;
      if (upd_nz) begin
        nxt_p_ff[FL_N] = alu_r[7];
        nxt_p_ff[FL_Z] = (alu_r == 8'h00);
      end
      if (upd_c) nxt_p_ff[FL_C] = alu_c;
      if (upd_v) nxt_p_ff[FL_V] = alu_v;
      case (ir_ff)
        OP_CLC, OP_SEC: nxt_p_ff[FL_C] = ir_ff[5];
        OP_CLI, OP_SEI: nxt_p_ff[FL_I] = ir_ff[5];
        OP_CLD, OP_SED: nxt_p_ff[FL_D] = ir_ff[5];
        OP_CLV: nxt_p_ff[FL_V] = 1'b0;
        default: begin
        end
      endcase
    end
    // interrupts are taken only between instructions
    if (done) begin
      if (!irq_n && !nxt_p_ff[FL_I]) begin
        nxt_addr_ff = {STACK_PAGE, nxt_sp_ff};
        nxt_data_out_ff = nxt_pc_ff[15:8];
        nxt_data_oe_ff = 1'b1;
        nxt_rw_ff = 1'b0;
        nxt_sp_ff = nxt_sp_ff - 8'h01;
        nxt_st_ff = S_IRQ1;
      end else begin
        nxt_addr_ff = nxt_pc_ff;
        nxt_sync_ff = 1'b1;
        nxt_cyc_ff = '0;
        nxt_st_ff = S_FETCH;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= S_INIT;
      cyc_ff <= '0;
      pc_ff <= ADDR_RESET;
      ir_ff <= '0;
      a_ff <= '0;
      x_ff <= '0;
      y_ff <= '0;
      sp_ff <= SP_RESET;
      p_ff <= P_RESET;
      lo_ff <= '0;
      vec_ff <= 1'b0;
      addr_ff <= ADDR_RESET;
      data_out_ff <= '0;
      data_oe_ff <= 1'b0;
      rw_ff <= 1'b1;
      sync_ff <= 1'b0;
    end else if (adv) begin
      st_ff <= nxt_st_ff;
      cyc_ff <= nxt_cyc_ff;
      pc_ff <= nxt_pc_ff;
      ir_ff <= nxt_ir_ff;
      a_ff <= nxt_a_ff;
      x_ff <= nxt_x_ff;
      y_ff <= nxt_y_ff;
      sp_ff <= nxt_sp_ff;
      p_ff <= nxt_p_ff;
      lo_ff <= nxt_lo_ff;
      vec_ff <= nxt_vec_ff;
      addr_ff <= nxt_addr_ff;
      data_out_ff <= nxt_data_out_ff;
      data_oe_ff <= nxt_data_oe_ff;
      rw_ff <= nxt_rw_ff;
      sync_ff <= nxt_sync_ff;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sync_fetch_a: assert property (sync_ff == (st_ff == S_FETCH && rw_ff))
    else $error("sync marker not tied to fetch cycle");
  ready_hold_a: assert property (sync_ff && !ready && clk_en |=> sync_ff && $stable(addr_ff))
    else $error("fetch did not freeze on ready low");
  write_go_a: assert property (!rw_ff && clk_en |=> st_ff != $past(st_ff))
    else $error("write cycle stalled by ready");
  reset_nowr_a: assert property (disable iff (1'b0) !reset_n |-> rw_ff && !data_oe_ff)
    else $error("write during reset");
  reset_start_a: assert property ($rose(reset_n) |-> st_ff == S_INIT)
    else $error("reset sequence not started");
  reset_vec_a: assert property (st_ff == S_VL && !vec_ff |-> addr_ff == VEC_RESET && p_ff[FL_I])
    else $error("reset vector fetch wrong");
  cyc_clear_a: assert property (sync_ff |-> cyc_ff == 3'h0)
    else $error("cycle counter not cleared at fetch");
  pc_step_a: assert property (st_ff == S_FETCH && adv |=> pc_ff == $past(pc_ff) + 16'h0001)
    else $error("pc did not step after fetch");
  page_zero_a: assert property (st_ff == S_MEM && (mode == page_zero_mode || mode == page_zero_indexed_mode)
    |-> addr_ff[15:8] == ZERO_PAGE)
    else $error("page-zero address left page zero");
  irq_vec_a: assert property (st_ff == S_VL && vec_ff |-> addr_ff == VEC_IRQ && p_ff[FL_I])
    else $error("interrupt vector fetch wrong");
endmodule

/* File: csd_mem_model.sv */
`timescale 1ns/1ps
module csd_mem_model (
  // clock and bus state
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // memory bus
  input wire logic [csd_pkg::ADDR_W-1:0] addr,
  input wire logic rw,
  input wire logic [csd_pkg::DATA_W-1:0] data_wr,
  output logic [csd_pkg::DATA_W-1:0] data_rd
);
  import csd_pkg::*;
  logic [7:0] mem [0:65535];
  logic [7:0] last_ff;
  // ----------------------------------------
  // zero-wait memory
  // ----------------------------------------
  // off-bus cycles show the inverse of the last byte, never a held value
  assign data_rd = rw ? mem[addr] : ~last_ff;
  // writes complete regardless of ready, as the core ignores it there
  always @(posedge core_clk) begin
    if (reset_n && clk_en && !rw) begin
      mem[addr] <= data_wr;
    end
    last_ff <= data_rd;
  end
endmodule

/* File: test_cpu_core_sequencer_decode.sv */
`timescale 1ns/1ps
module test_cpu_core_sequencer_decode;
  import csd_pkg::*;
  logic core_clk;
  logic reset_n;
  logic clk_en;
  logic ready;
  logic irq_n;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] data_in;
  logic [DATA_W-1:0] data_out_ff;
  logic data_oe_ff;
  logic rw_ff;
  logic sync_ff;
  logic rnd_on;
  logic [31:0] rnd;
  int bad_count;
  int n_checks;
  int n;
  logic [23:0] wq[$];
  logic [15:0] fq[$];
  logic [7:0] prog [0:26] = '{8'ha9, 8'h5a, 8'h85, 8'h10, 8'ha2, 8'h03, 8'h95, 8'h20, 8'h95, 8'hff,
    8'h0a, 8'h8d, 8'h34, 8'h12, 8'h48, 8'he8, 8'h8a, 8'h85, 8'h11, 8'h69, 8'h01, 8'h85, 8'h12,
    8'h58, 8'h4c, 8'h18, 8'h02};
  logic [15:0] fetch_list [0:16] = '{16'h0280, 16'h0282, 16'h0283,
    16'h0200, 16'h0202, 16'h0204, 16'h0206, 16'h0208, 16'h020a,
    16'h020b, 16'h020e, 16'h020f, 16'h0210, 16'h0211, 16'h0213, 16'h0215, 16'h0217};
  logic [23:0] write_list [0:9] = '{24'h00105a, 24'h00235a, 24'h00025a, 24'h1234b4, 24'h01ffb4,
    24'h001104, 24'h001205, 24'h01fe02, 24'h01fd18, 24'h01fc20};

  csd_core dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .ready(ready), .irq_n(irq_n),
    .addr_ff(addr_ff), .data_in(data_in), .data_out_ff(data_out_ff), .data_oe_ff(data_oe_ff),
    .rw_ff(rw_ff), .sync_ff(sync_ff)
  );
  csd_mem_model mem_u (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .addr(addr_ff), .rw(rw_ff),
    .data_wr(data_out_ff), .data_rd(data_in)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // clock, random stalls, watchdog
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // stalls come from both clk_en and ready, mixed over reads and writes
  always @(posedge core_clk) begin
    #1;
    if (rnd_on) begin
      rnd = xs(rnd);
      ready <= rnd[2:0] != 3'h0;
      clk_en <= rnd[5:3] != 3'h0;
    end
  end

  initial begin
    #60000;
    bad_count++;
    test_done();
  end

  // ----------------------------------------
  // output watchers
  // ----------------------------------------
  logic [23:0] w_exp;
  logic [15:0] f_exp;
  // looked at mid-cycle: bus settled, and the enables seen at the coming edge
  always @(negedge core_clk) begin
    if (!reset_n) begin
      check(rw_ff, 1);
      check(data_oe_ff, 0);
    end else if (clk_en && (ready || !rw_ff)) begin
      if (!rw_ff) begin
        w_exp = (wq.size() > 0) ? wq.pop_front() : 24'hffffff;
        check({addr_ff, data_out_ff}, w_exp);
        check(data_oe_ff, 1);
      end
      if (sync_ff && fq.size() > 0) begin
        f_exp = fq.pop_front();
        check(addr_ff, f_exp);
        check(rw_ff, 1);
      end
    end
  end

  // a frozen cycle must hold address and marker across the edge
  logic stall;
  logic [15:0] a_held;
  logic s_held;
  initial begin
    forever begin
      @(negedge core_clk);
      stall = reset_n && (!clk_en || (!ready && rw_ff));
      a_held = addr_ff;
      s_held = sync_ff;
      @(posedge core_clk);
      #2;
      if (stall && reset_n) begin
        check(addr_ff, a_held);
        check(sync_ff, s_held);
      end
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b1;
    clk_en = 1'b1;
    ready = 1'b1;
    irq_n = 1'b0;
    rnd_on = 1'b0;
    rnd = 32'hd95d;
    bad_count = 0;
    n_checks = 0;
    // a real falling edge, so the asynchronous reset is seen whatever the start order
    #1;
    reset_n = 1'b0;
    for (int i = 0; i < 65536; i++) begin
      mem_u.mem[i] = 8'hea;
    end
    for (int i = 0; i < 27; i++) begin
      mem_u.mem[16'h0200 + i] = prog[i];
    end
    mem_u.mem[16'h0300] = 8'h4c;
    mem_u.mem[16'h0301] = 8'h00;
    mem_u.mem[16'h0302] = 8'h03;
    // boot stub sets the stack pointer before any stack use, then jumps to the program
    mem_u.mem[16'h0280] = 8'ha2;
    mem_u.mem[16'h0281] = 8'hff;
    mem_u.mem[16'h0282] = 8'h9a;
    mem_u.mem[16'h0283] = 8'h4c;
    mem_u.mem[16'h0284] = 8'h00;
    mem_u.mem[16'h0285] = 8'h02;
    mem_u.mem[16'hfffc] = 8'h80;
    mem_u.mem[16'hfffd] = 8'h02;
    mem_u.mem[16'hfffe] = 8'h00;
    mem_u.mem[16'hffff] = 8'h03;
    // irq held low from the start: masked until the program clears the mask
    foreach (fetch_list[i]) fq.push_back(fetch_list[i]);
    foreach (write_list[i]) wq.push_back(write_list[i]);
    repeat (12) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    n = 0;
    while (addr_ff !== VEC_RESET && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(n, 6);
    check(rw_ff, 1);
    rnd_on = 1'b1;
    n = 0;
    while (wq.size() != 0 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    check(wq.size(), 0);
    check(fq.size(), 0);
    n = 0;
    while (!(sync_ff === 1'b1 && addr_ff === 16'h0300) && n < 200) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(addr_ff, 16'h0300);
    check(sync_ff, 1);
    // single-step: ready is the inverse of the marker, one step pulse lets one instruction through
    rnd_on = 1'b0;
    for (int k = 0; k < 12; k++) begin
      @(posedge core_clk);
      #1;
      clk_en = 1'b1;
      ready = !sync_ff || (k == 6);
    end
    check(addr_ff, 16'h0300);
    check(sync_ff, 1);
    test_done();
  end
endmodule
